// *** include/usb_pm_pkg.sv ***
/*
  Package for the USB suspend, version and LPM status block.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package usb_pm_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_STATUS_0 = 8'h00;
  localparam logic [7:0] OFS_HW_VERSION = 8'h04;
  localparam logic [7:0] OFS_LPM_CONTROL_2 = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_ROLE_CTRL = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RESUME_BIT = 10;
  localparam int SUSP_STATUS_BIT = 9;
  localparam int SUSP_ALLOW_BIT = 8;
  localparam int FADDR_LSB = 0;
  localparam int FADDR_W = 7;
  localparam int RC_BIT = 15;
  localparam int MAJOR_LSB = 10;
  localparam int MINOR_LSB = 0;
  localparam int LPM_ADDR_LSB = 8;
  localparam int ERR_BIT = 5;
  localparam int WAKE_BIT = 4;
  localparam int NC_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int NYET_BIT = 1;
  localparam int STALL_BIT = 0;
  localparam int NFLAGS = 6;
  localparam int ROLE_HOST_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // LPM handshake answer encodings on the link-side ports
  typedef enum logic [1:0] {
    LPM_ANS_NONE = 2'b00,
    LPM_ANS_ACK = 2'b01,
    LPM_ANS_NYET = 2'b10,
    LPM_ANS_STALL = 2'b11
  } lpm_ans_t;
endpackage : usb_pm_pkg

// *** hw/usb_pm_flags.sv ***
/*
  Sticky flag bank: hardware sets, writing a one clears, set wins.
  Assumes set and clear strobes are synchronous to the core clock.
*/
module usb_pm_flags #(
  parameter int W = 6
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_flags
);
  // ----------------------------------------------------------------
  // One flop per flag
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_flag
      // Set beats clear in the same cycle
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          o_flags[g] <= 1'b0;
        end else if (i_set[g]) begin
          o_flags[g] <= 1'b1;
        end else if (i_clr[g]) begin
          o_flags[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : usb_pm_flags

// *** hw/usb_pm_regs.sv ***
/*
  USB suspend, resume, function address, version and LPM status logic
  with an AXI4-Lite slave and one masked interrupt.
  Assumes link events arrive as one-cycle pulses on the core clock.
*/
module usb_pm_regs
  import usb_pm_pkg::*;
#(
  parameter logic release_candidate = 1'b0,
  parameter logic [4:0] major_version = 5'h00, // Arbitrary value
  parameter logic [9:0] minor_version = 10'h008 // Arbitrary value
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Link side
  input wire logic i_idle_detect,
  input wire logic i_wake_detect,
  input wire logic i_token_valid,
  input wire logic [6:0] i_token_addr,
  input wire logic i_lpm_rx,
  input wire logic i_lpm_state_ok,
  input wire logic i_rx_pending,
  input wire logic i_lpm_tx_ans_valid,
  input wire logic [1:0] i_lpm_tx_ans,
  output logic o_resume_drive,
  output logic o_suspended,
  output logic o_token_match,
  output logic [1:0] o_lpm_answer,
  output logic o_irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic resume_ctrl;
  logic suspended_status;
  logic suspend_allow;
  logic [6:0] device_function_addr;
  logic [6:0] lpm_payload_addr;
  logic [NFLAGS-1:0] irq_mask;
  logic host_role;
  logic [NFLAGS-1:0] flag_set;
  logic [NFLAGS-1:0] flag_clr;
  logic [NFLAGS-1:0] lpm_flags;
  logic [NFLAGS-1:0] irq_status;
  logic [NFLAGS-1:0] irq_clr;
  logic [NFLAGS-1:0] stat_set;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wake_event;
  logic host_susp_req;
  logic [31:0] next_rdata;
  logic next_rerr;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_fire = aw_held && w_held && !o_bvalid;
  // Ready flops are the inverse of the held flags, so outputs stay registered
  assign aw_held = !o_awready;
  assign w_held = !o_wready;

  // Address and data latch, in either order
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_addr <= 8'h00;
      w_data <= ZERO_WORD;
      w_strb <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        aw_addr <= i_awaddr;
      end else if (wr_fire) begin
        o_awready <= 1'b1;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end else if (wr_fire) begin
        o_wready <= 1'b1;
      end
    end
  end

  // Write response, unmapped offsets get SLVERR
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= (aw_addr == OFS_CTRL_STATUS_0 ||
                  aw_addr == OFS_HW_VERSION ||
                  aw_addr == OFS_LPM_CONTROL_2 ||
                  aw_addr == OFS_IRQ_STATUS ||
                  aw_addr == OFS_IRQ_MASK ||
                  aw_addr == OFS_ROLE_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software-written control
  // ----------------------------------------------------------------
  // Control register 0, role and mask; payload address
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      resume_ctrl <= 1'b0;
      suspend_allow <= 1'b0;
      device_function_addr <= 7'h00;
      lpm_payload_addr <= 7'h00;
      irq_mask <= '0;
      host_role <= 1'b0;
    end else if (wr_fire) begin
      if (aw_addr == OFS_CTRL_STATUS_0) begin
        if (w_strb[1]) begin
          resume_ctrl <= w_data[RESUME_BIT];
          suspend_allow <= w_data[SUSP_ALLOW_BIT];
        end
        if (w_strb[0]) begin
          device_function_addr <= w_data[FADDR_LSB +: FADDR_W];
        end
      end
      if (aw_addr == OFS_LPM_CONTROL_2 && w_strb[1]) begin
        lpm_payload_addr <= w_data[LPM_ADDR_LSB +: 7];
      end
      if (aw_addr == OFS_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[NFLAGS-1:0];
      end
      if (aw_addr == OFS_ROLE_CTRL && w_strb[0]) begin
        host_role <= w_data[ROLE_HOST_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Suspend state
  // ----------------------------------------------------------------
  assign host_susp_req = wr_fire && host_role && w_strb[1] &&
    aw_addr == OFS_CTRL_STATUS_0 && w_data[SUSP_STATUS_BIT];
  assign wake_event = suspended_status &&
    (i_wake_detect || resume_ctrl);

  // Enter on idle or host request when allowed, leave on any wake
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      suspended_status <= 1'b0;
    end else if (wake_event) begin
      suspended_status <= 1'b0;
    end else if (suspend_allow && (i_idle_detect || host_susp_req)) begin
      suspended_status <= 1'b1;
    end
  end

  // Resume drive follows the bit only while suspended or already driving
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_resume_drive <= 1'b0;
    end else begin
      o_resume_drive <= resume_ctrl &&
        (suspended_status || o_resume_drive);
    end
  end

  // Status mirror
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_suspended <= 1'b0;
    end else begin
      o_suspended <= suspended_status;
    end
  end

  // Token address match in device role
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_token_match <= 1'b0;
    end else begin
      o_token_match <= i_token_valid && !host_role &&
        i_token_addr == device_function_addr;
    end
  end

  // ----------------------------------------------------------------
  // LPM handling
  // ----------------------------------------------------------------
  // Device answer choice; priority STALL, then NYET, then ACK
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lpm_answer <= LPM_ANS_NONE;
    end else if (i_lpm_rx && !host_role) begin
      if (!i_lpm_state_ok) begin
        o_lpm_answer <= LPM_ANS_STALL;
      end else if (i_rx_pending) begin
        o_lpm_answer <= LPM_ANS_NYET;
      end else begin
        o_lpm_answer <= LPM_ANS_ACK;
      end
    end else begin
      o_lpm_answer <= LPM_ANS_NONE;
    end
  end

  // Hardware set pulses for each flag
  always_comb begin
    flag_set = '0;
    flag_set[WAKE_BIT] = wake_event;
    if (i_lpm_rx && !host_role) begin
      flag_set[ERR_BIT] = !i_lpm_state_ok;
      flag_set[NC_BIT] = i_lpm_state_ok && i_rx_pending;
      flag_set[NYET_BIT] = i_lpm_state_ok && i_rx_pending;
      flag_set[ACK_BIT] = i_lpm_state_ok && !i_rx_pending;
      flag_set[STALL_BIT] = !i_lpm_state_ok;
    end
    if (i_lpm_tx_ans_valid && host_role) begin
      flag_set[NC_BIT] = i_lpm_tx_ans == LPM_ANS_ACK;
      flag_set[ACK_BIT] = i_lpm_tx_ans == LPM_ANS_ACK;
      flag_set[NYET_BIT] = i_lpm_tx_ans == LPM_ANS_NYET;
      flag_set[STALL_BIT] = i_lpm_tx_ans == LPM_ANS_STALL;
    end
  end

  // LPM flags are never cleared by software
  assign flag_clr = '0;
  assign irq_clr = (wr_fire && aw_addr == OFS_IRQ_STATUS && w_strb[0]) ?
    w_data[NFLAGS-1:0] : '0;
  assign stat_set = flag_set;

  usb_pm_flags #(.W(NFLAGS)) u_lpm_flags (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_set(flag_set),
    .i_clr(flag_clr),
    .o_flags(lpm_flags)
  );

  usb_pm_flags #(.W(NFLAGS)) u_irq_flags (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_set(stat_set),
    .i_clr(irq_clr),
    .o_flags(irq_status)
  );

  // ----------------------------------------------------------------
  // Interrupt and read channel
  // ----------------------------------------------------------------
  // Level interrupt from masked sticky status
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // Read mux; unused bits stay zero
  always_comb begin
    next_rdata = ZERO_WORD;
    next_rerr = 1'b0;
    case (i_araddr)
      OFS_CTRL_STATUS_0: begin
        next_rdata[RESUME_BIT] = resume_ctrl;
        next_rdata[SUSP_STATUS_BIT] = suspended_status;
        next_rdata[SUSP_ALLOW_BIT] = suspend_allow;
        next_rdata[FADDR_LSB +: FADDR_W] = device_function_addr;
      end
      OFS_HW_VERSION: begin
        next_rdata[RC_BIT] = release_candidate;
        next_rdata[MAJOR_LSB +: 5] = major_version;
        next_rdata[MINOR_LSB +: 10] = minor_version;
      end
      OFS_LPM_CONTROL_2: begin
        next_rdata[LPM_ADDR_LSB +: 7] = lpm_payload_addr;
        next_rdata[NFLAGS-1:0] = lpm_flags;
      end
      OFS_IRQ_STATUS: next_rdata[NFLAGS-1:0] = irq_status;
      OFS_IRQ_MASK: next_rdata[NFLAGS-1:0] = irq_mask;
      OFS_ROLE_CTRL: next_rdata[ROLE_HOST_BIT] = host_role;
      default: next_rerr = 1'b1;
    endcase
  end

  // Read data registered on the same edge that takes the address
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
      o_rdata <= ZERO_WORD;
      o_rresp <= RESP_OKAY;
    end else if (i_arvalid && !o_rvalid) begin
      o_rvalid <= 1'b1;
      o_arready <= 1'b0;
      o_rdata <= next_rdata;
      o_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1; // Ready again once the answer is taken
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence lpm_bad_seq;
    i_lpm_rx && !host_role && !i_lpm_state_ok;
  endsequence

  chk_stall_on_bad: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    lpm_bad_seq |=> o_lpm_answer == LPM_ANS_STALL && lpm_flags[ERR_BIT])
    else $error("bad link state not stalled");

  chk_nyet_pending: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_lpm_rx && !host_role && i_lpm_state_ok && i_rx_pending |=>
      o_lpm_answer == LPM_ANS_NYET && lpm_flags[NC_BIT])
    else $error("pending data not answered with NYET");

  chk_host_ack_nc: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_lpm_tx_ans_valid && host_role && i_lpm_tx_ans == LPM_ANS_ACK |=>
      lpm_flags[NC_BIT] && lpm_flags[ACK_BIT])
    else $error("host ack flags not set");

  chk_nyet_flag: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_lpm_tx_ans_valid && host_role && i_lpm_tx_ans == LPM_ANS_NYET |=>
      lpm_flags[NYET_BIT])
    else $error("nyet flag not set");

  chk_wake_flag: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(suspended_status) |-> lpm_flags[WAKE_BIT])
    else $error("wake flag missing after resume");

  chk_flags_sticky: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    $past(lpm_flags) != '0 |-> (lpm_flags & $past(lpm_flags)) ==
      $past(lpm_flags))
    else $error("lpm flag cleared");

  chk_no_susp_deny: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !suspended_status && !suspend_allow |=> !suspended_status)
    else $error("suspend entered while not allowed");

  chk_resume_drive: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    suspended_status && resume_ctrl |=> o_resume_drive ##1 !o_suspended)
    else $error("resume not driven");

  chk_token_match: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_token_valid && !host_role && i_token_addr == device_function_addr
      |=> o_token_match)
    else $error("token address not matched");
endmodule : usb_pm_regs

// *** testbench/usb_far_end.sv ***
/*
  Far-side link model: the USB host or device beyond the link.
  Assumes the bench calls its task from procedural code on the core clock.
*/
module usb_far_end (
  input wire logic i_core_clk,
  output logic o_idle_detect,
  output logic o_wake_detect,
  output logic o_token_valid,
  output logic [6:0] o_token_addr,
  output logic o_lpm_rx,
  output logic o_lpm_state_ok,
  output logic o_rx_pending,
  output logic o_ans_valid,
  output logic [1:0] o_ans
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Quiet link at time zero
  // ----------------------------------------------------------------
  initial begin
    o_idle_detect = 1'b0;
    o_wake_detect = 1'b0;
    o_token_valid = 1'b0;
    o_token_addr = 7'h00;
    o_lpm_rx = 1'b0;
    o_lpm_state_ok = 1'b0;
    o_rx_pending = 1'b0;
    o_ans_valid = 1'b0;
    o_ans = 2'h0;
  end

  // One-cycle event: 0 idle, 1 wake, 2 token, 3 LPM, else host answer
  task automatic ev(input int k, input logic [6:0] a, input logic [1:0] v);
    @(posedge i_core_clk);
    case (k)
      0: o_idle_detect <= 1'b1;
      1: o_wake_detect <= 1'b1;
      2: begin
        o_token_valid <= 1'b1;
        o_token_addr <= a;
      end
      3: begin
        o_lpm_rx <= 1'b1;
        o_lpm_state_ok <= v[0];
        o_rx_pending <= v[1];
      end
      default: begin
        o_ans_valid <= 1'b1;
        o_ans <= v;
      end
    endcase
    @(posedge i_core_clk);
    o_idle_detect <= 1'b0;
    o_wake_detect <= 1'b0;
    o_token_valid <= 1'b0;
    o_lpm_rx <= 1'b0;
    o_ans_valid <= 1'b0;
    // Qualifiers lose meaning once the strobe drops
    o_token_addr <= ~a;
    o_ans <= ~v;
    o_lpm_state_ok <= ~v[0];
    o_rx_pending <= 1'b0;
  endtask : ev
endmodule : usb_far_end

// *** testbench/usb_suspend_lpm_status_tb.sv ***
/*
  Self-checking bench for the USB suspend, version and LPM status block.
  Assumes the package, the register block and the far-side link model.
*/
module usb_suspend_lpm_status_tb import usb_pm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic VER_RC = 1'b1; // Arbitrary build values
  localparam logic [4:0] VER_MAJ = 5'h13;
  localparam logic [9:0] VER_MIN = 10'h2A5;
  localparam logic [31:0] VER_WORD = {16'h0000, VER_RC, VER_MAJ, VER_MIN};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, last_resp, tx_ans, lpm_ans;
  logic idle_det, wake_det, tok_v, lpm_rx, st_ok, rx_pend, ans_v;
  logic [6:0] tok_a;
  logic res_drv, susp, tok_match, irq;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;

  always #4 core_clk = ~core_clk;

  usb_pm_regs #(.release_candidate(VER_RC), .major_version(VER_MAJ),
    .minor_version(VER_MIN)) u_usb_pm_regs (
    .i_core_clk(core_clk), .i_rst(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_idle_detect(idle_det),
    .i_wake_detect(wake_det), .i_token_valid(tok_v),
    .i_token_addr(tok_a), .i_lpm_rx(lpm_rx), .i_lpm_state_ok(st_ok),
    .i_rx_pending(rx_pend), .i_lpm_tx_ans_valid(ans_v),
    .i_lpm_tx_ans(tx_ans), .o_resume_drive(res_drv),
    .o_suspended(susp), .o_token_match(tok_match),
    .o_lpm_answer(lpm_ans), .o_irq(irq));

  usb_far_end u_usb_far_end (
    .i_core_clk(core_clk), .o_idle_detect(idle_det),
    .o_wake_detect(wake_det), .o_token_valid(tok_v),
    .o_token_addr(tok_a), .o_lpm_rx(lpm_rx), .o_lpm_state_ok(st_ok),
    .o_rx_pending(rx_pend), .o_ans_valid(ans_v), .o_ans(tx_ans));

  // ----------------------------------------------------------------
  // Bus master and comparison
  // ----------------------------------------------------------------
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge core_clk);
    last_resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge core_clk);
    last_resp = rresp;
    rready <= 1'b0;
    check(rdata, exp);
  endtask : rd_chk

  // Let the register land and the lagging outputs follow
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_version();
    rd_chk(OFS_HW_VERSION, VER_WORD);
    wr(OFS_HW_VERSION, 32'hFFFF_FFFF);
    check(32'(last_resp), 32'(RESP_OKAY));
    rd_chk(OFS_HW_VERSION, VER_WORD);
    wr(8'h20, 32'h0000_0001);
    check(32'(last_resp), 32'(RESP_SLVERR));
    rd_chk(OFS_LPM_CONTROL_2, ZERO_WORD);
    rd_chk(8'h20, ZERO_WORD);
    check(32'(last_resp), 32'(RESP_SLVERR));
  endtask : t_version

  task automatic t_address();
    wr(OFS_CTRL_STATUS_0, 32'h0000_0025);
    u_usb_far_end.ev(2, 7'h25, 2'h0);
    #1 check(32'(tok_match), 32'h0000_0001);
    u_usb_far_end.ev(2, 7'h26, 2'h0);
    #1 check(32'(tok_match), 32'h0000_0000);
    rd_chk(OFS_CTRL_STATUS_0, 32'h0000_0025);
    wr(OFS_LPM_CONTROL_2, 32'hFFFF_FFFF);
    rd_chk(OFS_LPM_CONTROL_2, 32'h0000_7F00);
  endtask : t_address

  task automatic t_lpm_dev();
    logic [1:0] v[3] = '{2'b01, 2'b11, 2'b00};
    logic [1:0] a[3] = '{LPM_ANS_ACK, LPM_ANS_NYET, LPM_ANS_STALL};
    logic [31:0] f[3] = '{32'h0000_7F04, 32'h0000_7F0E, 32'h0000_7F2F};
    for (int i = 0; i < 3; i++) begin
      u_usb_far_end.ev(3, 7'h00, v[i]);
      #1 check(32'(lpm_ans), 32'(a[i]));
      rd_chk(OFS_LPM_CONTROL_2, f[i]);
    end
    rd_chk(OFS_IRQ_STATUS, 32'h0000_002F);
  endtask : t_lpm_dev

  // A one in the mask lets that status bit reach the interrupt
  task automatic t_irq();
    check(32'(irq), 32'h0000_0000);
    wr(OFS_IRQ_MASK, 32'h0000_003F);
    settle();
    check(32'(irq), 32'h0000_0001);
    wr(OFS_IRQ_STATUS, 32'h0000_003F);
    rd_chk(OFS_IRQ_STATUS, ZERO_WORD);
    check(32'(irq), 32'h0000_0000);
    rd_chk(OFS_LPM_CONTROL_2, 32'h0000_7F2F);
    wr(OFS_IRQ_MASK, 32'h0000_0010);
    rd_chk(OFS_IRQ_MASK, 32'h0000_0010);
    settle();
    check(32'(irq), 32'h0000_0000);
  endtask : t_irq

  task automatic t_suspend();
    u_usb_far_end.ev(0, 7'h00, 2'h0);
    settle();
    check(32'(susp), 32'h0000_0000);
    wr(OFS_CTRL_STATUS_0, 32'h0000_0325);
    settle();
    check(32'(susp), 32'h0000_0000);
    u_usb_far_end.ev(0, 7'h00, 2'h0);
    settle();
    check(32'(susp), 32'h0000_0001);
    rd_chk(OFS_CTRL_STATUS_0, 32'h0000_0325);
    wr(OFS_CTRL_STATUS_0, 32'h0000_0525);
    settle();
    check(32'(res_drv), 32'h0000_0001);
    check(32'(susp), 32'h0000_0000);
    check(32'(irq), 32'h0000_0001);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0010);
    repeat (20) @(posedge core_clk);
    wr(OFS_CTRL_STATUS_0, 32'h0000_0125);
    settle();
    check(32'(res_drv), 32'h0000_0000);
    wr(OFS_IRQ_STATUS, 32'h0000_0010);
    u_usb_far_end.ev(0, 7'h00, 2'h0);
    u_usb_far_end.ev(1, 7'h00, 2'h0);
    settle();
    check(32'(susp), 32'h0000_0000);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0010);
    wr(OFS_IRQ_STATUS, 32'h0000_0010);
  endtask : t_suspend

  task automatic t_host();
    wr(OFS_ROLE_CTRL, 32'h0000_0001);
    u_usb_far_end.ev(3, 7'h00, 2'b01);
    #1 check(32'(lpm_ans), 32'(LPM_ANS_NONE));
    u_usb_far_end.ev(4, 7'h00, LPM_ANS_ACK);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_000C);
    u_usb_far_end.ev(4, 7'h00, LPM_ANS_NYET);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_000E);
    wr(OFS_CTRL_STATUS_0, 32'h0000_0325);
    settle();
    check(32'(susp), 32'h0000_0001);
    u_usb_far_end.ev(1, 7'h00, 2'h0);
    settle();
    check(32'(susp), 32'h0000_0000);
  endtask : t_host

  // ----------------------------------------------------------------
  // Sequence, timeout and verdict
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_version();
    t_address();
    t_lpm_dev();
    t_irq();
    t_suspend();
    t_host();
    end_sim();
  end
endmodule : usb_suspend_lpm_status_tb
